// File: rpsi_top.sv
// rpsi_top: rx packet statistics, latched status and interrupt enable over apb
// assumes: packet-end strobes are one-cycle pulses from the rx packet processor
//
// Overview of operation
// - irq when enable bit 7 and bad check packet flag set
// - irq when enable bit 6 and aborted packet flag set
// - irq when enable bit 5 and invalid packet flag set
// - irq when enable bit 4 and undersize packet flag set
// - irq when enable bit 3 and oversize packet flag set
// - irq when enable bit 2 and bad check count flag set
// - irq when enable bit 1 and abort count flag set
// - irq when enable bit 0 and size violation count flag set
// - enable bit zero disables, one enables; all reset to zero
// - 24-bit good packet count in three byte registers
// - good count includes packets later dropped by loopback or overflow
// - good count counts fixed-size chunks in clear channel mode
// - 24-bit bad check packet count at 10Ch to 10Eh
// - bad check packet bytes go to aborted bytes, not good bytes
// - good count bits 7:0 lowest byte, bits 23:16 at 10Ah
// - bad check count least significant byte at lowest address
// - aborted count 24 bits, bits 7:0 at 110h, 15:8 at 111h
// - packet flags latch on bad check, abort, invalid, undersize, oversize
// - count flags latch on zero-to-one of count nonzero bits
// - aborted count counts packets ending with abort
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module rpsi_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [rpsi_pkg::RPSI_ADDR_W-1:0] paddr_in,
    input wire logic [rpsi_pkg::RPSI_DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [rpsi_pkg::RPSI_DATA_W-1:0] prdata_out,
    input wire logic clear_channel_in,
    input wire logic chunk_done_in,
    input wire logic pkt_end_in,
    input wire logic pkt_abort_in,
    input wire logic pkt_bad_check_in,
    input wire logic pkt_invalid_in,
    input wire logic pkt_undersize_in,
    input wire logic pkt_oversize_in,
    input wire logic [rpsi_pkg::RPSI_BYTES_W-1:0] pkt_bytes_in,
    input wire logic size_viol_count_nonzero_in,
    output logic good_bytes_add_out,
    output logic aborted_bytes_add_out,
    output logic [rpsi_pkg::RPSI_BYTES_W-1:0] bytes_add_value_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [rpsi_pkg::RPSI_REG_W-1:0] rx_status_irq_enable_ff;
    logic [rpsi_pkg::RPSI_REG_W-1:0] rx_latched_status_reg;
    logic [rpsi_pkg::RPSI_REG_W-1:0] rx_live_status_reg;
    logic [rpsi_pkg::RPSI_REG_W-1:0] flag_set;
    logic [rpsi_pkg::RPSI_REG_W-1:0] flag_clr;
    logic [rpsi_pkg::RPSI_CNT_W-1:0] good_packet_counter;
    logic [rpsi_pkg::RPSI_CNT_W-1:0] bad_check_packet_counter;
    logic [rpsi_pkg::RPSI_CNT_W-1:0] aborted_packet_counter;
    logic good_inc;
    logic bad_check_inc;
    logic abort_inc;
    logic size_viol;
    logic bad_check_count_nonzero;
    logic abort_count_nonzero;
    logic bad_check_nonzero_prev_ff;
    logic abort_nonzero_prev_ff;
    logic size_viol_nonzero_prev_ff;
    logic setup_phase;
    logic access_phase;
    logic wr_take;
    logic addr_hit;
    logic [rpsi_pkg::RPSI_DATA_W-1:0] nxt_prdata;
    logic [rpsi_pkg::RPSI_DATA_W-1:0] prdata_ff;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic good_bytes_add_ff;
    logic aborted_bytes_add_ff;
    logic [rpsi_pkg::RPSI_BYTES_W-1:0] bytes_add_value_ff;
    logic irq_ff;

    // ------------------------------------------------------------
    // packet classification
    // ------------------------------------------------------------
    assign size_viol = pkt_invalid_in | pkt_undersize_in | pkt_oversize_in;

    always_comb begin
        if (clear_channel_in) begin
            good_inc = chunk_done_in;
        end else begin
            good_inc = pkt_end_in & ~pkt_abort_in & ~pkt_bad_check_in & ~size_viol;
        end
    end

    assign bad_check_inc = pkt_end_in & ~clear_channel_in & pkt_bad_check_in;
    assign abort_inc = pkt_end_in & ~clear_channel_in & pkt_abort_in;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    rpsi_sat_counter u_good_cnt (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .inc_in(good_inc),
        .count_out(good_packet_counter),
        .nonzero_out()
    );

    rpsi_sat_counter u_bad_check_cnt (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .inc_in(bad_check_inc),
        .count_out(bad_check_packet_counter),
        .nonzero_out(bad_check_count_nonzero)
    );

    rpsi_sat_counter u_abort_cnt (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .inc_in(abort_inc),
        .count_out(aborted_packet_counter),
        .nonzero_out(abort_count_nonzero)
    );

    // ------------------------------------------------------------
    // byte routing to the external byte counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            good_bytes_add_ff <= 1'b0;
            aborted_bytes_add_ff <= 1'b0;
        end else begin
            good_bytes_add_ff <= good_inc & ~clear_channel_in;
            aborted_bytes_add_ff <= pkt_end_in & ~clear_channel_in & ~good_inc;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bytes_add_value_ff <= rpsi_pkg::RPSI_RST_BYTES;
        end else if (pkt_end_in) begin
            bytes_add_value_ff <= pkt_bytes_in;
        end
    end

    assign good_bytes_add_out = good_bytes_add_ff;
    assign aborted_bytes_add_out = aborted_bytes_add_ff;
    assign bytes_add_value_out = bytes_add_value_ff;

    // ------------------------------------------------------------
    // live status and nonzero edge detect
    // ------------------------------------------------------------
    always_comb begin
        rx_live_status_reg = rpsi_pkg::RPSI_RST_FLAGS;
        rx_live_status_reg[rpsi_pkg::RPSI_BIT_BAD_CHECK_COUNT] = bad_check_count_nonzero;
        rx_live_status_reg[rpsi_pkg::RPSI_BIT_ABORT_COUNT] = abort_count_nonzero;
        rx_live_status_reg[rpsi_pkg::RPSI_BIT_SIZE_VIOL_COUNT] = size_viol_count_nonzero_in;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bad_check_nonzero_prev_ff <= 1'b0;
            abort_nonzero_prev_ff <= 1'b0;
            size_viol_nonzero_prev_ff <= 1'b0;
        end else begin
            bad_check_nonzero_prev_ff <= bad_check_count_nonzero;
            abort_nonzero_prev_ff <= abort_count_nonzero;
            size_viol_nonzero_prev_ff <= size_viol_count_nonzero_in;
        end
    end

    // ------------------------------------------------------------
    // latched status flags
    // ------------------------------------------------------------
    always_comb begin
        flag_set = rpsi_pkg::RPSI_RST_FLAGS;
        if (pkt_end_in && !clear_channel_in) begin
            flag_set[rpsi_pkg::RPSI_BIT_BAD_CHECK_PKT] = pkt_bad_check_in;
            flag_set[rpsi_pkg::RPSI_BIT_ABORT_PKT] = pkt_abort_in;
            flag_set[rpsi_pkg::RPSI_BIT_INVALID_PKT] = pkt_invalid_in;
            flag_set[rpsi_pkg::RPSI_BIT_UNDERSIZE_PKT] = pkt_undersize_in;
            flag_set[rpsi_pkg::RPSI_BIT_OVERSIZE_PKT] = pkt_oversize_in;
        end
        flag_set[rpsi_pkg::RPSI_BIT_BAD_CHECK_COUNT] =
            bad_check_count_nonzero & ~bad_check_nonzero_prev_ff;
        flag_set[rpsi_pkg::RPSI_BIT_ABORT_COUNT] =
            abort_count_nonzero & ~abort_nonzero_prev_ff;
        flag_set[rpsi_pkg::RPSI_BIT_SIZE_VIOL_COUNT] =
            size_viol_count_nonzero_in & ~size_viol_nonzero_prev_ff;
    end

    always_comb begin
        flag_clr = rpsi_pkg::RPSI_RST_FLAGS;
        if (wr_take && (paddr_in == rpsi_pkg::RPSI_ADDR_LATCHED_STATUS) && pstrb_in[0]) begin
            flag_clr = pwdata_in[rpsi_pkg::RPSI_REG_W-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < rpsi_pkg::RPSI_FLAG_N; gi = gi + 1) begin : g_flag
            rpsi_flag_latch u_flag (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .set_in(flag_set[gi]),
                .clr_in(flag_clr[gi]),
                .flag_out(rx_latched_status_reg[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // apb phases
    // ------------------------------------------------------------
    assign setup_phase = psel_in & ~penable_in;
    assign access_phase = psel_in & penable_in;
    assign wr_take = access_phase & pwrite_in;
    assign pready_out = access_phase;

    // ------------------------------------------------------------
    // interrupt enable register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_status_irq_enable_ff <= rpsi_pkg::RPSI_RST_IRQ_EN;
        end else if (wr_take && (paddr_in == rpsi_pkg::RPSI_ADDR_IRQ_EN) && pstrb_in[0]) begin
            rx_status_irq_enable_ff <= pwdata_in[rpsi_pkg::RPSI_REG_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // read decode, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        nxt_prdata = rpsi_pkg::RPSI_RST_RDATA;
        addr_hit = 1'b1;
        case (paddr_in)
            rpsi_pkg::RPSI_ADDR_LIVE_STATUS: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = rx_live_status_reg;
            end
            rpsi_pkg::RPSI_ADDR_LATCHED_STATUS: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = rx_latched_status_reg;
            end
            rpsi_pkg::RPSI_ADDR_IRQ_EN: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = rx_status_irq_enable_ff;
            end
            rpsi_pkg::RPSI_ADDR_GOOD_B0: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = good_packet_counter[7:0];
            end
            rpsi_pkg::RPSI_ADDR_GOOD_B1: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = good_packet_counter[15:8];
            end
            rpsi_pkg::RPSI_ADDR_GOOD_B2: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = good_packet_counter[23:16];
            end
            rpsi_pkg::RPSI_ADDR_BAD_CHECK_B0: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = bad_check_packet_counter[7:0];
            end
            rpsi_pkg::RPSI_ADDR_BAD_CHECK_B1: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = bad_check_packet_counter[15:8];
            end
            rpsi_pkg::RPSI_ADDR_BAD_CHECK_B2: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = bad_check_packet_counter[23:16];
            end
            rpsi_pkg::RPSI_ADDR_ABORT_B0: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = aborted_packet_counter[7:0];
            end
            rpsi_pkg::RPSI_ADDR_ABORT_B1: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = aborted_packet_counter[15:8];
            end
            rpsi_pkg::RPSI_ADDR_ABORT_B2: begin
                nxt_prdata[rpsi_pkg::RPSI_REG_W-1:0] = aborted_packet_counter[23:16];
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_pslverr = ~addr_hit;
        if (pwrite_in && addr_hit) begin
            nxt_pslverr = (paddr_in != rpsi_pkg::RPSI_ADDR_IRQ_EN) &&
                (paddr_in != rpsi_pkg::RPSI_ADDR_LATCHED_STATUS);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_ff <= rpsi_pkg::RPSI_RST_RDATA;
        end else if (setup_phase && !pwrite_in) begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata_out = prdata_ff;
    assign pslverr_out = pslverr_ff & access_phase;

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(rx_latched_status_reg & rx_status_irq_enable_ff);
        end
    end

    assign irq_out = irq_ff;

endmodule
`default_nettype wire

// File: rpsi_pkg.sv
// rpsi_pkg: register map, field positions and widths of the rx packet statistics block
// assumes: apb byte addresses are four times the register index
package rpsi_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int RPSI_ADDR_W = 12;
    localparam int RPSI_DATA_W = 32;
    localparam int RPSI_REG_W = 8;
    localparam int RPSI_CNT_W = 24;
    localparam int RPSI_BYTES_W = 16;
    localparam int RPSI_FLAG_N = 8;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [8:0] RPSI_IDX_LIVE_STATUS = 9'h104;
    localparam logic [8:0] RPSI_IDX_LATCHED_STATUS = 9'h105;
    localparam logic [8:0] RPSI_IDX_IRQ_EN = 9'h106;
    localparam logic [8:0] RPSI_IDX_GOOD_B0 = 9'h108;
    localparam logic [8:0] RPSI_IDX_GOOD_B1 = 9'h109;
    localparam logic [8:0] RPSI_IDX_GOOD_B2 = 9'h10a;
    localparam logic [8:0] RPSI_IDX_BAD_CHECK_B0 = 9'h10c;
    localparam logic [8:0] RPSI_IDX_BAD_CHECK_B1 = 9'h10d;
    localparam logic [8:0] RPSI_IDX_BAD_CHECK_B2 = 9'h10e;
    localparam logic [8:0] RPSI_IDX_ABORT_B0 = 9'h110;
    localparam logic [8:0] RPSI_IDX_ABORT_B1 = 9'h111;
    localparam logic [8:0] RPSI_IDX_ABORT_B2 = 9'h112;

    // ------------------------------------------------------------
    // byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] RPSI_ADDR_LIVE_STATUS = {1'b0, RPSI_IDX_LIVE_STATUS, 2'b00};
    localparam logic [11:0] RPSI_ADDR_LATCHED_STATUS = {1'b0, RPSI_IDX_LATCHED_STATUS, 2'b00};
    localparam logic [11:0] RPSI_ADDR_IRQ_EN = {1'b0, RPSI_IDX_IRQ_EN, 2'b00};
    localparam logic [11:0] RPSI_ADDR_GOOD_B0 = {1'b0, RPSI_IDX_GOOD_B0, 2'b00};
    localparam logic [11:0] RPSI_ADDR_GOOD_B1 = {1'b0, RPSI_IDX_GOOD_B1, 2'b00};
    localparam logic [11:0] RPSI_ADDR_GOOD_B2 = {1'b0, RPSI_IDX_GOOD_B2, 2'b00};
    localparam logic [11:0] RPSI_ADDR_BAD_CHECK_B0 = {1'b0, RPSI_IDX_BAD_CHECK_B0, 2'b00};
    localparam logic [11:0] RPSI_ADDR_BAD_CHECK_B1 = {1'b0, RPSI_IDX_BAD_CHECK_B1, 2'b00};
    localparam logic [11:0] RPSI_ADDR_BAD_CHECK_B2 = {1'b0, RPSI_IDX_BAD_CHECK_B2, 2'b00};
    localparam logic [11:0] RPSI_ADDR_ABORT_B0 = {1'b0, RPSI_IDX_ABORT_B0, 2'b00};
    localparam logic [11:0] RPSI_ADDR_ABORT_B1 = {1'b0, RPSI_IDX_ABORT_B1, 2'b00};
    localparam logic [11:0] RPSI_ADDR_ABORT_B2 = {1'b0, RPSI_IDX_ABORT_B2, 2'b00};

    // ------------------------------------------------------------
    // bit positions shared by enable and latched registers
    // ------------------------------------------------------------
    localparam int RPSI_BIT_BAD_CHECK_PKT = 7;
    localparam int RPSI_BIT_ABORT_PKT = 6;
    localparam int RPSI_BIT_INVALID_PKT = 5;
    localparam int RPSI_BIT_UNDERSIZE_PKT = 4;
    localparam int RPSI_BIT_OVERSIZE_PKT = 3;
    localparam int RPSI_BIT_BAD_CHECK_COUNT = 2;
    localparam int RPSI_BIT_ABORT_COUNT = 1;
    localparam int RPSI_BIT_SIZE_VIOL_COUNT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RPSI_RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RPSI_RST_FLAGS = 8'h00;
    localparam logic [23:0] RPSI_RST_COUNT = 24'h000000;
    localparam logic [31:0] RPSI_RST_RDATA = 32'h00000000;
    localparam logic [15:0] RPSI_RST_BYTES = 16'h0000;

endpackage

// File: rpsi_sat_counter.sv
// rpsi_sat_counter: saturating event counter
// assumes: inc_in is a one-cycle pulse synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none

module rpsi_sat_counter (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic inc_in,
    output var logic [rpsi_pkg::RPSI_CNT_W-1:0] count_out,
    output var logic nonzero_out
);

    // ------------------------------------------------------------
    // count
    // ------------------------------------------------------------
    logic [rpsi_pkg::RPSI_CNT_W-1:0] count_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_ff <= rpsi_pkg::RPSI_RST_COUNT;
        end else if (inc_in && (count_ff != {rpsi_pkg::RPSI_CNT_W{1'b1}})) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign count_out = count_ff;
    assign nonzero_out = (count_ff != rpsi_pkg::RPSI_RST_COUNT);

endmodule
`default_nettype wire

// File: rpsi_flag_latch.sv
// rpsi_flag_latch: sticky flag, hardware set wins over software clear
// assumes: set_in and clr_in are synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none

module rpsi_flag_latch (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output var logic flag_out
);

    // ------------------------------------------------------------
    // flag
    // ------------------------------------------------------------
    logic flag_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_ff <= 1'b0;
        end else if (set_in) begin
            flag_ff <= 1'b1;
        end else if (clr_in) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag_out = flag_ff;

endmodule
`default_nettype wire

// File: rpsi_assertions.sv
// rpsi_assertions: port-level checks of rpsi_top
// assumes: bound into rpsi_top from the testbench top, one clock
`timescale 1ns/10ps
`default_nettype none
module rpsi_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [31:0] prdata_out,
    input wire logic clear_channel_in,
    input wire logic pkt_end_in,
    input wire logic pkt_bad_check_in,
    input wire logic [15:0] pkt_bytes_in,
    input wire logic good_bytes_add_out,
    input wire logic aborted_bytes_add_out,
    input wire logic [15:0] bytes_add_value_out,
    input wire logic irq_out
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic pkt_q;
    assign pkt_q = pkt_end_in && !clear_channel_in;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_ready_no_wait: assert property (psel_in && penable_in |-> pready_out)
        else $error("no ready in access");
    a_bad_bytes: assert property (pkt_q && pkt_bad_check_in |=> aborted_bytes_add_out)
        else $error("bad check bytes not aborted");
    a_one_add: assert property (pkt_q |=> good_bytes_add_out ^ aborted_bytes_add_out)
        else $error("byte add not one-hot");
    a_no_add: assert property (!pkt_q |=> !good_bytes_add_out && !aborted_bytes_add_out)
        else $error("byte add without packet");
    a_add_value: assert property (pkt_q |=> bytes_add_value_out == $past(pkt_bytes_in))
        else $error("byte add value wrong");
    a_err_unmapped: assert property (psel_in && penable_in && paddr_in[11:8] != 4'h4
        |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
        else $error("unmapped access not refused");
    a_err_ro: assert property (psel_in && penable_in && pwrite_in &&
        paddr_in == rpsi_pkg::RPSI_ADDR_GOOD_B0 |-> pslverr_out)
        else $error("counter write not refused");
    a_rd_upper: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_irq_reset: assert property ($fell(sys_rst_in) |-> !irq_out)
        else $error("irq after reset");
    a_irq_hold: assert property (irq_out && !psel_in && !$past(psel_in) |=> irq_out)
        else $error("irq dropped without clear");
endmodule
`default_nettype wire

// File: rpsi_host_model.sv
// rpsi_host_model: apb master standing in for the host processor
// assumes: shares clk_in with the slave, called at any time
`timescale 1ns/10ps
`default_nettype none
module rpsi_host_model (
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    input wire logic [31:0] prdata_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [11:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic [3:0] pstrb_out
);
    // ------------------------------------------------------------
    // transfer
    // ------------------------------------------------------------
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0;
        pstrb_out = 4'hf;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic t);
        int n;
        t = 1'b1;
        q = 32'h0;
        e = 1'b0;
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        for (n = 0; n < 16 && t; n++) begin
            @(posedge clk_in);
            if (pready_in === 1'b1) begin
                q = prdata_in;
                e = pslverr_in;
                t = 1'b0;
            end
        end
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask
endmodule
`default_nettype wire

// File: rpsi_top_test.sv
// rpsi_top_test: directed checks of the rx packet statistics block
// assumes: rpsi_pkg, rpsi_top, host model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module rpsi_top_test;
    logic clk_in, sys_rst_in, psel, pen, pwr, prdy, perr, cc, chunk, pend, ab, bad, inv, und, ovr;
    logic svnz, gadd, aadd, irq;
    logic [11:0] paddr;
    logic [31:0] pwd, prd;
    logic [3:0] pstrb;
    logic [15:0] pbytes, bval;
    int err_total, check_count;
    // ------------------------------------------------------------
    // harness and tasks
    // ------------------------------------------------------------
    rpsi_host_model host_u (.clk_in(clk_in), .pready_in(prdy), .pslverr_in(perr), .prdata_in(prd),
        .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
        .pwdata_out(pwd), .pstrb_out(pstrb));
    rpsi_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(pstrb), .pready_out(prdy),
        .pslverr_out(perr), .prdata_out(prd), .clear_channel_in(cc), .chunk_done_in(chunk),
        .pkt_end_in(pend), .pkt_abort_in(ab), .pkt_bad_check_in(bad), .pkt_invalid_in(inv),
        .pkt_undersize_in(und), .pkt_oversize_in(ovr), .pkt_bytes_in(pbytes),
        .size_viol_count_nonzero_in(svnz), .good_bytes_add_out(gadd),
        .aborted_bytes_add_out(aadd), .bytes_add_value_out(bval), .irq_out(irq));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic tally_and_finish;
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        logic t;
        host_u.xfer(w, a, d, q, e, t);
        if (t) begin
            err_total++;
            tally_and_finish;
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask
    task automatic ev(input logic [4:0] f);
        @(posedge clk_in);
        pend <= 1'b1;
        {ab, bad, inv, und, ovr} <= f;
        pbytes <= {11'h000, f};
        @(posedge clk_in);
        pend <= 1'b0;
        {ab, bad, inv, und, ovr} <= 5'h00;
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        for (logic [9:0] i = 10'h104; i <= 10'h112; i++) begin
            bus(1'b0, {i, 2'b00}, 32'h0, q, e);
            check(q, 32'h0);
            check({31'h0, e}, {31'h0, i == 10'h107 || i == 10'h10b || i == 10'h10f});
        end
    endtask
    task automatic t_enable;
        logic [31:0] q;
        logic e;
        bus(1'b1, rpsi_pkg::RPSI_ADDR_IRQ_EN, 32'ha5, q, e);
        rdc(rpsi_pkg::RPSI_ADDR_IRQ_EN, 32'ha5);
        bus(1'b1, rpsi_pkg::RPSI_ADDR_GOOD_B0, 32'h55, q, e);
        check({31'h0, e}, 32'h1);
        bus(1'b0, 12'h000, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        bus(1'b1, rpsi_pkg::RPSI_ADDR_IRQ_EN, 32'h0, q, e);
    endtask
    task automatic t_irq;
        logic [4:0] ft [8] = '{5'h00, 5'h10, 5'h08, 5'h01, 5'h02, 5'h04, 5'h10, 5'h08};
        logic [31:0] q;
        logic [31:0] m;
        logic e;
        for (int b = 0; b < 8; b++) begin
            m = 32'h1 << b;
            if (b == 0) begin
                @(posedge clk_in);
                svnz <= 1'b1;
            end else begin
                ev(ft[b]);
            end
            repeat (4) @(posedge clk_in);
            check({31'h0, irq}, 32'h0);
            bus(1'b0, rpsi_pkg::RPSI_ADDR_LATCHED_STATUS, 32'h0, q, e);
            check(q & m, m);
            bus(1'b1, rpsi_pkg::RPSI_ADDR_IRQ_EN, m, q, e);
            repeat (3) @(posedge clk_in);
            check({31'h0, irq}, 32'h1);
            bus(1'b1, rpsi_pkg::RPSI_ADDR_LATCHED_STATUS, 32'hff, q, e);
            repeat (3) @(posedge clk_in);
            check({31'h0, irq}, 32'h0);
            bus(1'b1, rpsi_pkg::RPSI_ADDR_IRQ_EN, 32'h0, q, e);
        end
    endtask
    task automatic t_counts;
        logic [7:0] ce [11] = '{8'h03, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
                                8'h02, 8'h00, 8'h00};
        @(posedge clk_in);
        pend <= 1'b1;
        repeat (257) @(posedge clk_in);
        pend <= 1'b0;
        chunk <= 1'b1;
        @(posedge clk_in);
        cc <= 1'b1;
        repeat (2) @(posedge clk_in);
        chunk <= 1'b0;
        ev(5'h08);
        cc <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rdc({2'b01, 8'h08 + 8'(i), 2'b00}, {24'h0, ce[i]});
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        check_count = 0;
        sys_rst_in = 1'b1;
        {cc, chunk, pend, ab, bad, inv, und, ovr, svnz} = 9'h000;
        pbytes = 16'h0000;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_enable;
        t_irq;
        t_counts;
        tally_and_finish;
    end
endmodule
bind rpsi_top rpsi_checker chk_u (.*);
`default_nettype wire
